// [rtl/pmd_pkg.sv]
// constants and types shared by the pulse-input motor driver logic
`default_nettype none
package pmd_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int BLINK_HALF_MS   = 250;
  localparam int BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int FILTER_UNIT_US  = 100;
  localparam int FILTER_UNIT_CYC = CLK_HZ / 1_000_000 * FILTER_UNIT_US;
  localparam int RES_STEPS_LOW   = 1000;
  localparam int RES_STEPS_HIGH  = 10000;
  localparam int HOME_SPEED_SHIFT = 2;

  // -----------------------------------------------------------------
  // register map (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_INMAP      = 8'h04;
  localparam logic [7:0] ADDR_OUTMAP     = 8'h08;
  localparam logic [7:0] ADDR_CMD        = 8'h0C;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_POSITION   = 8'h14;
  localparam logic [7:0] ADDR_HOME_POS   = 8'h18;
  localparam logic [7:0] ADDR_JOG_PERIOD = 8'h1C;
  localparam logic [7:0] ADDR_ANGLE      = 8'h20;

  // control register fields
  localparam int CTRL_RES_BIT   = 0;
  localparam int CTRL_MODE_BIT  = 1;
  localparam int CTRL_CUR_LSB   = 4;
  localparam int CTRL_FIL_LSB   = 8;
  localparam logic [11:0] CTRL_RESET = 12'h1F0;
  localparam int CMD_HOME_SET_BIT = 0;

  // function codes for the general input and output pins
  localparam int FN_W = 3;
  localparam int N_IO = 6;
  localparam logic [2:0] FN_GO_HOME = 3'h0;
  localparam logic [2:0] FN_STOP    = 3'h1;
  localparam logic [2:0] FN_FREE    = 3'h2;
  localparam logic [2:0] FN_CLEAR   = 3'h3;
  localparam logic [2:0] FN_JOG_FWD = 3'h4;
  localparam logic [2:0] FN_JOG_REV = 3'h5;
  localparam logic [2:0] OF_HOME_END = 3'h0;
  localparam logic [2:0] OF_IN_POS   = 3'h1;
  localparam logic [2:0] OF_PULSE_INPUT_PREPARED  = 3'h2;
  localparam logic [2:0] OF_READY    = 3'h3;
  localparam logic [2:0] OF_MOVE     = 3'h4;
  localparam logic [2:0] OF_FAULT_NC = 3'h5;
  localparam logic [17:0] INMAP_RESET  = 18'h2C688;
  localparam logic [17:0] OUTMAP_RESET = 18'h2C688;
  localparam logic [31:0] JOG_PERIOD_RESET = 32'h0000C350;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_HOME, ST_JOG} pmd_state_t;

endpackage
`default_nettype wire

// [rtl/pmd_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pmd_sync import pmd_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic         reset_n,
  // pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pmd_sync_st_t;

  pmd_sync_st_t s_q, s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // a change counts only once stage two and three agree
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.lvl;

endmodule // pmd_sync
`default_nettype wire

// [rtl/pmd_quad.sv]
// quadrature feedback generator driven by motor steps
`timescale 1ns/1ns
`default_nettype none
module pmd_quad import pmd_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic ce,
  input  wire logic reset_n,
  // step events
  input  wire logic step,
  input  wire logic dir_fwd,
  // feedback pair
  output logic      quad_a,
  output logic      quad_b
);

  typedef struct packed {
    logic [1:0] phase;
    logic       a;
    logic       b;
  } pmd_quad_st_t;

  pmd_quad_st_t s_q, s_d;
  logic [1:0]   nph;

  always_comb begin
    s_d = s_q;
    nph = s_q.phase;
    // forward steps let B lead A, reverse steps let A lead B
    if (step) begin
      nph = dir_fwd ? s_q.phase + 2'h1 : s_q.phase - 2'h1;
    end
    s_d.phase = nph;
    s_d.a     = nph[1];
    s_d.b     = nph[1] ^ nph[0];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign quad_a = s_q.a;
  assign quad_b = s_q.b;

endmodule // pmd_quad
`default_nettype wire

// [rtl/pmd_driver.sv]
// pulse-input motor driver control, status and register logic
`timescale 1ns/1ns
`default_nettype none
module pmd_driver import pmd_pkg::*; #(
  parameter int BLINK_CYC  = BLINK_HALF_CYC,
  parameter int FILTER_CYC = FILTER_UNIT_CYC,
  parameter int RES_LOW    = RES_STEPS_LOW,
  parameter int RES_HIGH   = RES_STEPS_HIGH
) (
  // clock, enable and reset
  input  wire logic              clk,
  input  wire logic              ce,
  input  wire logic              reset_n,
  // axi4-lite write channels
  input  wire logic        [7:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic       [31:0] s_axi_wdata,
  input  wire logic        [3:0] s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic             [1:0] s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic        [7:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic            [31:0] s_axi_rdata,
  output logic             [1:0] s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // pulse inputs (pins)
  input  wire logic              clockwise_pulse_in,
  input  wire logic              counterclockwise_pulse_in,
  // general inputs and outputs (pins)
  input  wire logic [N_IO-1:0]   gen_in,
  output logic      [N_IO-1:0]   gen_out,
  // protection trip from the power stage (pin)
  input  wire logic              protect_trip,
  // motor stage
  output logic                   motor_step,
  output logic                   motor_dir_fwd,
  output logic                   motor_excited,
  output logic             [3:0] motor_current_level,
  // feedback and indicators
  output logic                   quad_a_out,
  output logic                   quad_b_out,
  output logic                   power_led,
  output logic                   alarm_led,
  output logic                   ready_led
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic  [7:0] awaddr;
    logic [31:0] wdata;
    logic  [3:0] wstrb;
    logic        bvalid;
    logic  [1:0] bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic  [1:0] rresp;
    logic [11:0] ctrl;
    logic [17:0] inmap;
    logic [17:0] outmap;
    logic [31:0] jog_period;
    logic [31:0] home_pos;
    logic        home_valid;
    logic [31:0] pos;
    logic [31:0] angle;
    pmd_state_t  state;
    logic [31:0] timer;
    logic [31:0] settle;
    logic  [7:0] in_prev;
    logic        alarm;
    logic        home_end;
    logic        ready;
    logic        step;
    logic        dir_fwd;
    logic        excited;
    logic  [3:0] cur;
    logic [31:0] blink_cnt;
    logic        blink;
    logic        power_led;
    logic        alarm_led;
    logic        ready_led;
    logic [N_IO-1:0] gen_out;
  } pmd_st_t;

  pmd_st_t s_q, s_d;

  logic [8:0] sync_lvl;

  pmd_sync #(.W(9)) pmd_sync_i (
    .clk       (clk),
    .ce        (ce),
    .reset_n   (reset_n),
    .pin_in    ({protect_trip, counterclockwise_pulse_in, clockwise_pulse_in, gen_in}),
    .level_out (sync_lvl)
  );

  pmd_quad pmd_quad_i (
    .clk     (clk),
    .ce      (ce),
    .reset_n (reset_n),
    .step    (s_q.step),
    .dir_fwd (s_q.dir_fwd),
    .quad_a  (quad_a_out),
    .quad_b  (quad_b_out)
  );

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // level of an input function: any pin mapped to it that is high
  function automatic logic fn_on(input logic [17:0] map, input logic [N_IO-1:0] pins,
                                 input logic [2:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_IO; i++) begin
      if (map[i*FN_W +: FN_W] == code && pins[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  logic [N_IO-1:0] gin;
  logic        lv_cw, lv_ccw, trip;
  logic        stop_r, free_r, jog_f, jog_r, home_rise, clr_rise;
  logic        cw_rise, ccw_rise, go, step_now, dir_now, moving;
  logic [31:0] spr, period, wr_val, settle_load;
  logic  [5:0] ofn;

  always_comb begin
    s_d       = s_q;
    gin       = sync_lvl[N_IO-1:0];
    lv_cw     = sync_lvl[6];
    lv_ccw    = sync_lvl[7];
    trip      = sync_lvl[8];
    s_d.in_prev = sync_lvl[7:0];
    stop_r    = fn_on(s_q.inmap, gin, FN_STOP);
    free_r    = fn_on(s_q.inmap, gin, FN_FREE);
    jog_f     = fn_on(s_q.inmap, gin, FN_JOG_FWD);
    jog_r     = fn_on(s_q.inmap, gin, FN_JOG_REV);
    home_rise = fn_on(s_q.inmap, gin, FN_GO_HOME)
                & !fn_on(s_q.inmap, s_q.in_prev[N_IO-1:0], FN_GO_HOME);
    clr_rise  = fn_on(s_q.inmap, gin, FN_CLEAR)
                & !fn_on(s_q.inmap, s_q.in_prev[N_IO-1:0], FN_CLEAR);
    cw_rise   = lv_cw & !s_q.in_prev[6];
    ccw_rise  = lv_ccw & !s_q.in_prev[7];
    spr       = s_q.ctrl[CTRL_RES_BIT] ? 32'(RES_HIGH) : 32'(RES_LOW);
    step_now  = 1'b0;
    dir_now   = s_q.dir_fwd;
    wr_val    = 32'h0;

    // --- alarm: a trip in the clear cycle keeps the alarm set
    s_d.alarm = trip | (s_q.alarm & !clr_rise);
    s_d.excited = !free_r;
    go = s_q.excited & !s_q.alarm & !stop_r;

    // --- motion sequencing
    period = (s_q.state == ST_HOME) ? (s_q.jog_period >> HOME_SPEED_SHIFT) : s_q.jog_period;
    s_d.timer = s_q.timer + 32'h1;
    if (!go) begin
      s_d.state = ST_IDLE;
      s_d.timer = 32'h0;
    end else begin
      unique case (s_q.state)
        ST_IDLE: begin
          s_d.timer = 32'h0;
          if (home_rise && s_q.home_valid && s_q.pos != s_q.home_pos) begin
            s_d.state = ST_HOME;
          end else if (home_rise && s_q.home_valid) begin
            s_d.home_end = 1'b1;
          end else if (jog_f ^ jog_r) begin
            s_d.state = ST_JOG;
          end else if (!s_q.ctrl[CTRL_MODE_BIT]) begin
            // simultaneous edges on both trains cancel out
            if (cw_rise ^ ccw_rise) begin
              step_now = 1'b1;
              dir_now  = cw_rise;
            end
          end else if (cw_rise) begin
            step_now = 1'b1;
            dir_now  = !lv_ccw;
          end
        end
        ST_HOME: begin
          if (s_q.pos == s_q.home_pos) begin
            s_d.state    = ST_IDLE;
            s_d.home_end = 1'b1;
          end else if (s_q.timer >= period) begin
            s_d.timer = 32'h0;
            step_now  = 1'b1;
            dir_now   = $signed(s_q.home_pos) > $signed(s_q.pos);
          end
        end
        ST_JOG: begin
          if (!(jog_f ^ jog_r)) begin
            s_d.state = ST_IDLE;
          end else if (s_q.timer >= period) begin
            s_d.timer = 32'h0;
            step_now  = 1'b1;
            dir_now   = jog_f;
          end
        end
      endcase
    end

    // --- step bookkeeping
    s_d.step = step_now;
    if (step_now) begin
      s_d.dir_fwd = dir_now;
      if (s_q.state != ST_HOME) begin
        s_d.home_end = 1'b0;
      end
      s_d.pos = dir_now ? s_q.pos + 32'h1 : s_q.pos - 32'h1;
      if (dir_now) begin
        s_d.angle = (s_q.angle + 32'h1 >= spr) ? 32'h0 : s_q.angle + 32'h1;
      end else begin
        s_d.angle = (s_q.angle == 32'h0) ? spr - 32'h1 : s_q.angle - 32'h1;
      end
    end

    // --- settling: a longer filter setting holds motion-active longer
    settle_load = 32'(FILTER_CYC) * {28'h0, s_q.ctrl[CTRL_FIL_LSB +: 4]};
    if (step_now) begin
      s_d.settle = (settle_load == 32'h0) ? 32'h1 : settle_load;
    end else if (s_q.settle != 32'h0) begin
      s_d.settle = s_q.settle - 32'h1;
    end
    moving = (s_q.settle != 32'h0) || (s_q.state != ST_IDLE);

    s_d.ready = go & (s_q.state == ST_IDLE) & !moving;
    // running current is the base, standstill current is half of it
    if (!s_q.excited) begin
      s_d.cur = 4'h0;
    end else begin
      s_d.cur = moving ? s_q.ctrl[CTRL_CUR_LSB +: 4] : s_q.ctrl[CTRL_CUR_LSB +: 4] >> 1;
    end

    // --- indicators
    s_d.power_led = 1'b1;
    if (s_q.alarm) begin
      if (s_q.blink_cnt >= 32'(BLINK_CYC - 1)) begin
        s_d.blink_cnt = 32'h0;
        s_d.blink     = !s_q.blink;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 32'h1;
      end
    end else begin
      s_d.blink_cnt = 32'h0;
      s_d.blink     = 1'b1;
    end
    s_d.alarm_led = s_q.alarm & s_q.blink;
    // registered beside gen_out so the lamp never leads the ready pin
    s_d.ready_led = s_q.ready;

    // --- general outputs through the remap table
    ofn[OF_HOME_END] = s_q.home_end;
    ofn[OF_IN_POS]   = !moving & s_q.excited & !s_q.alarm;
    ofn[OF_PULSE_INPUT_PREPARED]  = s_q.ready;
    ofn[OF_READY]    = s_q.ready;
    ofn[OF_MOVE]     = moving;
    ofn[OF_FAULT_NC] = !s_q.alarm;
    for (int i = 0; i < N_IO; i++) begin
      s_d.gen_out[i] = ofn[s_q.outmap[i*FN_W +: FN_W]];
    end

    // --- axi write: address and data may arrive in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got  = 1'b1;
      s_d.awready = 1'b0;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got  = 1'b1;
      s_d.wready = 1'b0;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case (s_q.awaddr)
        ADDR_CTRL: begin
          wr_val     = wmerge({20'h0, s_q.ctrl}, s_q.wdata, s_q.wstrb);
          s_d.ctrl   = wr_val[11:0];
        end
        ADDR_INMAP: begin
          wr_val     = wmerge({14'h0, s_q.inmap}, s_q.wdata, s_q.wstrb);
          s_d.inmap  = wr_val[17:0];
        end
        ADDR_OUTMAP: begin
          wr_val     = wmerge({14'h0, s_q.outmap}, s_q.wdata, s_q.wstrb);
          s_d.outmap = wr_val[17:0];
        end
        ADDR_JOG_PERIOD: begin
          s_d.jog_period = wmerge(s_q.jog_period, s_q.wdata, s_q.wstrb);
        end
        ADDR_CMD: begin
          if (s_q.wstrb[0] && s_q.wdata[CMD_HOME_SET_BIT]) begin
            s_d.home_pos   = s_q.pos;
            s_d.home_valid = 1'b1;
          end
        end
        ADDR_STATUS, ADDR_POSITION, ADDR_HOME_POS, ADDR_ANGLE: begin
          s_d.bresp = RESP_OKAY;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // --- axi read
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL:       s_d.rdata = {20'h0, s_q.ctrl};
        ADDR_INMAP:      s_d.rdata = {14'h0, s_q.inmap};
        ADDR_OUTMAP:     s_d.rdata = {14'h0, s_q.outmap};
        ADDR_CMD:        s_d.rdata = 32'h0;
        ADDR_STATUS:     s_d.rdata = {22'h0, s_q.state, s_q.home_valid, s_q.excited,
                                      s_q.alarm, moving, ofn[OF_IN_POS], s_q.home_end,
                                      s_q.ready, 1'b0};
        ADDR_POSITION:   s_d.rdata = s_q.pos;
        ADDR_HOME_POS:   s_d.rdata = s_q.home_pos;
        ADDR_JOG_PERIOD: s_d.rdata = s_q.jog_period;
        ADDR_ANGLE:      s_d.rdata = s_q.angle;
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q            <= '0;
      s_q.awready    <= 1'b1;
      s_q.wready     <= 1'b1;
      s_q.arready    <= 1'b1;
      s_q.ctrl       <= CTRL_RESET;
      s_q.inmap      <= INMAP_RESET;
      s_q.outmap     <= OUTMAP_RESET;
      s_q.jog_period <= JOG_PERIOD_RESET;
      s_q.state      <= ST_IDLE;
      s_q.blink      <= 1'b1;
      s_q.power_led  <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign s_axi_awready       = s_q.awready;
  assign s_axi_wready        = s_q.wready;
  assign s_axi_bresp         = s_q.bresp;
  assign s_axi_bvalid        = s_q.bvalid;
  assign s_axi_arready       = s_q.arready;
  assign s_axi_rdata         = s_q.rdata;
  assign s_axi_rresp         = s_q.rresp;
  assign s_axi_rvalid        = s_q.rvalid;
  assign gen_out             = s_q.gen_out;
  assign motor_step          = s_q.step;
  assign motor_dir_fwd       = s_q.dir_fwd;
  assign motor_excited       = s_q.excited;
  assign motor_current_level = s_q.cur;
  assign power_led           = s_q.power_led;
  assign alarm_led           = s_q.alarm_led;
  assign ready_led           = s_q.ready_led;

endmodule // pmd_driver
`default_nettype wire

// [verification/pmd_driver_props.sv]
// port assertions for the pulse-input motor driver
`timescale 1ns/1ns
`default_nettype none
module pmd_driver_props import pmd_pkg::*; (
  // clock and reset
  input wire logic            clk,
  input wire logic            reset_n,
  // general pins and trip
  input wire logic [N_IO-1:0] gen_in,
  input wire logic [N_IO-1:0] gen_out,
  input wire logic            protect_trip,
  // motor stage and indicators
  input wire logic            motor_step,
  input wire logic            motor_dir_fwd,
  input wire logic            motor_excited,
  input wire logic            quad_a_out,
  input wire logic            quad_b_out,
  input wire logic            power_led,
  input wire logic            alarm_led,
  input wire logic            ready_led
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_power; power_led; endproperty
  a_power: assert property (p_power) else $error("power led dark");
  // a cleared alarm may cut the lit phase short
  property p_blink; $rose(alarm_led) |=> (alarm_led || gen_out[5])[*7]; endproperty
  a_blink: assert property (p_blink) else $error("alarm led lit phase short");
  property p_rdy_led; ready_led == gen_out[3]; endproperty
  a_rdy_led: assert property (p_rdy_led) else $error("ready led differs");
  property p_move; motor_step |=> gen_out[4]; endproperty
  a_move: assert property (p_move) else $error("no motion flag after step");
  property p_trip; $rose(protect_trip) |-> ##[1:10] !gen_out[5]; endproperty
  a_trip: assert property (p_trip) else $error("fault status stays closed");
  property p_stop; gen_in[1][*8] |-> !motor_step; endproperty
  a_stop: assert property (p_stop) else $error("step while stopped");
  property p_free; gen_in[2][*8] |-> !motor_excited; endproperty
  a_free: assert property (p_free) else $error("excited while freed");
  property p_quad; motor_step |=> {quad_a_out ^ $past(quad_a_out), quad_b_out ^ $past(quad_b_out)} ==
    ((($past(quad_a_out) == $past(quad_b_out)) == $past(motor_dir_fwd)) ? 2'h1 : 2'h2); endproperty
  a_quad: assert property (p_quad) else $error("quadrature order wrong");
endmodule // pmd_driver_props
bind pmd_driver pmd_driver_props pmd_driver_props_i (.*);
`default_nettype wire

// [verification/pmd_ctrl_model.sv]
// controller model issuing step pulses on the two pulse pins, or in single mode pulses on cw_pin with the direction level on ccw_pin
`timescale 1ns/1ns
`default_nettype none
module pmd_ctrl_model (
  // clock and mode
  input  wire logic clk,
  input  wire logic single_mode,
  input  wire logic prepared,
  // pulse pins
  output var logic  cw_pin,
  output var logic  ccw_pin
);
  initial begin
    cw_pin = 1'h0;
    ccw_pin = 1'h0;
  end
  // four-cycle phases keep every level past the input filter
  task automatic send(input int n, input logic rev);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      while (prepared !== 1'h1) @(posedge clk);
      if (single_mode) ccw_pin <= rev;
      repeat (4) @(posedge clk);
      if (single_mode || !rev) cw_pin <= 1'h1;
      else ccw_pin <= 1'h1;
      repeat (4) @(posedge clk);
      cw_pin <= 1'h0;
      if (!single_mode) ccw_pin <= 1'h0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // pmd_ctrl_model
`default_nettype wire

// [verification/test_pmd_driver.sv]
// self-checking bench for the motor driver
`timescale 1ns/1ns
`default_nettype none
module test_pmd_driver;
  import pmd_pkg::*;
  logic clk = 1'h0, ce = 1'h1, reset_n = 1'h0, protect_trip = 1'h0, single_mode = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] gen_in = 6'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, motor_step, motor_dir_fwd;
  wire logic motor_excited, quad_a_out, quad_b_out, power_led, alarm_led, ready_led;
  wire logic clockwise_pulse_in, counterclockwise_pulse_in;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [5:0] gen_out;
  wire logic [3:0] motor_current_level;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  pmd_driver #(.BLINK_CYC(8), .FILTER_CYC(4)) pmd_driver_i (.*);
  pmd_ctrl_model pmd_ctrl_model_i (.clk(clk), .single_mode(single_mode), .prepared(gen_out[2]),
    .cw_pin(clockwise_pulse_in), .ccw_pin(counterclockwise_pulse_in));
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, {32'h0, RESP_OKAY});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk({s_axi_rresp, s_axi_rdata}, e);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    repeat (10) @(posedge clk);
    chk(power_led, 34'h1);
    chk(gen_out, 34'h2E);
    chk(ready_led, 34'h1);
    chk(motor_current_level, 34'h7);
    rchk(ADDR_CTRL, {RESP_OKAY, 32'h1F0});
    rchk(ADDR_INMAP, {RESP_OKAY, 32'h2C688});
    rchk(8'h3C, {RESP_SLVERR, 32'h0});
    wr(ADDR_JOG_PERIOD, 32'h28);
    pmd_ctrl_model_i.send(3, 1'h0);
    pmd_ctrl_model_i.send(1, 1'h1);
    rchk(ADDR_POSITION, {RESP_OKAY, 32'h2});
    wr(ADDR_CTRL, 32'h1F2);
    single_mode <= 1'h1;
    pmd_ctrl_model_i.send(3, 1'h1);
    rchk(ADDR_POSITION, {RESP_OKAY, 32'hFFFFFFFF});
    rchk(ADDR_ANGLE, {RESP_OKAY, 32'h3E7});
    wr(ADDR_CMD, 32'h1);
    rchk(ADDR_HOME_POS, {RESP_OKAY, 32'hFFFFFFFF});
    pmd_ctrl_model_i.send(3, 1'h0);
    gen_in <= 6'h01;
    repeat (10) @(posedge clk);
    gen_in <= 6'h00;
    while (gen_out[0] !== 1'h1) @(posedge clk);
    rchk(ADDR_POSITION, {RESP_OKAY, 32'hFFFFFFFF});
    gen_in <= 6'h10;
    repeat (200) @(posedge clk);
    chk({gen_out[4], motor_dir_fwd}, 34'h3);
    gen_in <= 6'h20;
    repeat (200) @(posedge clk);
    chk({gen_out[4], motor_dir_fwd}, 34'h2);
    gen_in <= 6'h00;
    repeat (100) @(posedge clk);
    chk({gen_out[4], gen_out[0]}, 34'h0);
    gen_in <= 6'h12;
    repeat (200) @(posedge clk);
    chk(gen_out[4], 34'h0);
    gen_in <= 6'h04;
    repeat (20) @(posedge clk);
    chk({motor_excited, motor_current_level}, 34'h0);
    gen_in <= 6'h00;
    protect_trip <= 1'h1;
    repeat (40) @(posedge clk);
    chk({gen_out[5], gen_out[3], ready_led}, 34'h0);
    protect_trip <= 1'h0;
    gen_in <= 6'h08;
    repeat (20) @(posedge clk);
    chk(gen_out[5], 34'h1);
    final_report;
  end
endmodule // test_pmd_driver
`default_nettype wire
